// *** rtl/tcc_core.sv ***
// Overview of operation
// - Overflow flag bit 7 sets when counter returns to zero after reaching modulo, or in center mode when it turns down at modulo.
// - Flag clears only after a status read with flag set, then writing zero.
// - A new overflow during the clear sequence restarts it; flag stays set.
// - Reset clears the flag; writing one to the flag does nothing.
// - With enable bit 6 set, interrupt requested while flag is one; reset clears.
// - Center-align bit 5 resets low; low counts up, high counts up/down.
// - Clock source bits 4:3 pick none, bus, fixed system, or external.
// - Fixed clock acts as bus clock when no enabled PLL or FLL.
// - External source synchronised to bus clock inside; fixed clock arrives synchronised.
// - Prescale field divides selected clock by two to the field value.
// - Prescaler follows source selection and synchronisation.
// - New prescale value acts on the clock cycle after the register update.
// - Reading either counter byte latches both until the other byte is read.
// - Latch rearmed by reset or any status/control write.
// - Reset zeroes counter; any counter byte write zeroes it and rearms latch.
// - Debug halt freezes counter and latch state even across counter reads.
// - During debug halt, status/control or counter writes still rearm the latch.
// - After modulo the counter restarts at zero when counting up, or turns down in center mode; modulo zero runs free.
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tcc_core (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // timer environment
  input wire logic [15:0] modulo_value,
  input wire logic debug_halt_state,
  input wire logic fll_enabled,
  input wire logic fixed_clk_sync,
  input wire logic ext_clk,
  // status out
  output logic irq,
  output logic center_align_select,
  output logic count_down
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic dph_valid;
    logic dph_write;
    logic [7:0] dph_addr;
    logic hready;
    logic [31:0] hrdata;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic center_align_select;
    logic [1:0] clock_source_select;
    logic [2:0] prescale_select;
    logic clr_armed;
    logic [15:0] cnt;
    logic down;
    logic [6:0] pre;
    logic [15:0] latch;
    logic held;
    logic held_hi;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic fix_prev;
    logic [tcc_pkg::EVT_WIDTH-1:0] evt_sts;
    logic [tcc_pkg::EVT_WIDTH-1:0] evt_en;
    logic irq;
  } tcc_state_t;

  tcc_state_t q;
  tcc_state_t d;

  logic acc;
  logic wr;
  logic src_tick;
  logic cnt_en;
  logic ovf;
  logic turn;
  logic [15:0] top;
  logic [6:0] mask;
  logic [7:0] rd_byte;
  logic [7:0] rd_addr;
  logic sc_wr;
  logic cnt_wr;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    acc = hsel && htrans[1] && hready;
    rd_addr = haddr[7:0];
    wr = q.dph_valid && q.dph_write;
    sc_wr = wr && (q.dph_addr == tcc_pkg::OFS_STATUS_CONTROL);
    cnt_wr = wr && ((q.dph_addr == tcc_pkg::OFS_COUNTER_HIGH) || (q.dph_addr == tcc_pkg::OFS_COUNTER_LOW));
    rd_byte = 8'h00;
    ovf = 1'b0;
    turn = 1'b0;

    // bus: zero wait states, always okay
    d.hready = 1'b1;
    d.dph_valid = acc;
    d.dph_write = acc && hwrite;
    d.dph_addr = acc ? rd_addr : q.dph_addr;

    // external source: s1 feeds only s2
    d.ext_s1 = ext_clk;
    d.ext_s2 = q.ext_s1;
    d.ext_s3 = q.ext_s2;
    d.fix_prev = fixed_clk_sync;

    // source selection ahead of the prescaler
    case (q.clock_source_select)
      tcc_pkg::CLKSRC_BUS: src_tick = 1'b1;
      tcc_pkg::CLKSRC_FIXED: src_tick = fll_enabled ? (fixed_clk_sync && !q.fix_prev) : 1'b1;
      tcc_pkg::CLKSRC_EXTERNAL: src_tick = q.ext_s2 && !q.ext_s3;
      default: src_tick = 1'b0;
    endcase

    // mask from the registered field, so a new value bites a cycle later
    mask = 7'(({1'b0, 7'h7F}) >> (3'h7 - q.prescale_select));
    if (src_tick && !debug_halt_state) begin
      d.pre = q.pre + 7'h01;
    end
    cnt_en = src_tick && !debug_halt_state && ((q.pre & mask) == mask);

    // counter
    top = (modulo_value == tcc_pkg::MODULO_DISABLED) ? tcc_pkg::CNT_FREE_TOP : modulo_value;
    if (cnt_en) begin
      if (!q.center_align_select) begin
        d.down = 1'b0;
        if (q.cnt == top) begin
          d.cnt = 16'h0000;
          ovf = 1'b1;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end else if (!q.down) begin
        if (q.cnt >= top) begin
          d.down = 1'b1;
          d.cnt = q.cnt - 16'h0001;
          ovf = 1'b1;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end else if (q.cnt == 16'h0000) begin
        d.down = 1'b0;
        d.cnt = 16'h0001;
        turn = 1'b1;
      end else begin
        d.cnt = q.cnt - 16'h0001;
      end
    end

    // data-phase writes; status/control and counter writes rearm the latch even in debug halt
    if (sc_wr) begin
      d.overflow_irq_enable = hwdata[tcc_pkg::POS_OVERFLOW_IRQ_ENABLE];
      d.center_align_select = hwdata[tcc_pkg::POS_CENTER_ALIGN_SELECT];
      d.clock_source_select = hwdata[tcc_pkg::POS_CLOCK_SOURCE_HI:tcc_pkg::POS_CLOCK_SOURCE_LO];
      d.prescale_select = hwdata[tcc_pkg::POS_PRESCALE_HI:tcc_pkg::POS_PRESCALE_LO];
      d.held = 1'b0;
      // a one leaves the flag alone; a zero clears only once armed
      if (q.clr_armed && !hwdata[tcc_pkg::POS_OVERFLOW_FLAG]) begin
        d.overflow_flag = 1'b0;
      end
      d.clr_armed = 1'b0;
    end
    if (!d.center_align_select) begin
      d.down = 1'b0;
    end
    if (cnt_wr) begin
      d.cnt = tcc_pkg::RST_COUNTER;
      d.down = 1'b0;
      d.pre = 7'h00;
      d.held = 1'b0;
    end
    if (wr && (q.dph_addr == tcc_pkg::OFS_EVENT_CLEAR)) begin
      d.evt_sts = q.evt_sts & ~hwdata[tcc_pkg::EVT_WIDTH-1:0];
    end
    if (wr && (q.dph_addr == tcc_pkg::OFS_EVENT_ENABLE)) begin
      d.evt_en = hwdata[tcc_pkg::EVT_WIDTH-1:0];
    end

    // address-phase reads and their side effects
    if (acc && !hwrite) begin
      case (rd_addr)
        tcc_pkg::OFS_STATUS_CONTROL: begin
          rd_byte = {q.overflow_flag, q.overflow_irq_enable, q.center_align_select,
                     q.clock_source_select, q.prescale_select};
          if (q.overflow_flag) begin
            d.clr_armed = 1'b1;
          end
        end
        tcc_pkg::OFS_COUNTER_HIGH: begin
          if (debug_halt_state) begin
            rd_byte = q.held ? q.latch[15:8] : q.cnt[15:8];
          end else if (!q.held) begin
            rd_byte = q.cnt[15:8];
            d.latch = q.cnt;
            d.held = 1'b1;
            d.held_hi = 1'b1;
          end else begin
            rd_byte = q.latch[15:8];
            if (!q.held_hi) begin
              d.held = 1'b0;
            end
          end
        end
        tcc_pkg::OFS_COUNTER_LOW: begin
          if (debug_halt_state) begin
            rd_byte = q.held ? q.latch[7:0] : q.cnt[7:0];
          end else if (!q.held) begin
            rd_byte = q.cnt[7:0];
            d.latch = q.cnt;
            d.held = 1'b1;
            d.held_hi = 1'b0;
          end else begin
            rd_byte = q.latch[7:0];
            if (q.held_hi) begin
              d.held = 1'b0;
            end
          end
        end
        default: rd_byte = 8'h00;
      endcase
    end
    d.hrdata = 32'h0000_0000;
    if (acc && !hwrite) begin
      case (rd_addr)
        tcc_pkg::OFS_MODULO: d.hrdata = {16'h0000, modulo_value};
        tcc_pkg::OFS_EVENT_STATUS: d.hrdata = {30'h0000_0000, q.evt_sts};
        tcc_pkg::OFS_EVENT_ENABLE: d.hrdata = {30'h0000_0000, q.evt_en};
        default: d.hrdata = {24'h00_0000, rd_byte};
      endcase
    end

    // a new overflow wins over clear and restarts the sequence
    if (ovf) begin
      d.overflow_flag = 1'b1;
      d.clr_armed = 1'b0;
    end
    // events set over clears in the same cycle
    d.evt_sts[tcc_pkg::POS_EVT_OVERFLOW] = d.evt_sts[tcc_pkg::POS_EVT_OVERFLOW] | ovf;
    d.evt_sts[tcc_pkg::POS_EVT_BOTTOM_TURN] = d.evt_sts[tcc_pkg::POS_EVT_BOTTOM_TURN] | turn;

    d.irq = (d.overflow_flag && d.overflow_irq_enable) || (|(d.evt_sts & d.evt_en));
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.hready <= 1'b1;
      q.overflow_flag <= 1'b0;
      q.overflow_irq_enable <= 1'b0;
      q.center_align_select <= 1'b0;
      q.clock_source_select <= tcc_pkg::RST_CLOCK_SOURCE;
      q.prescale_select <= tcc_pkg::RST_PRESCALE;
      q.cnt <= tcc_pkg::RST_COUNTER;
      q.evt_sts <= tcc_pkg::RST_EVENTS;
      q.evt_en <= tcc_pkg::RST_EVENTS;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops; response is always okay
  assign hreadyout = q.hready;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign irq = q.irq;
  assign center_align_select = q.center_align_select;
  assign count_down = q.down;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_OVF_SETS_FLAG: assert property (ovf |=> q.overflow_flag)
    else $error("overflow did not set the flag");

  AST_FLAG_CLEAR_NEEDS_ARM: assert property ($fell(q.overflow_flag) |-> $past(q.clr_armed) && $past(sc_wr))
    else $error("flag cleared without armed sequence");

  AST_OVF_DURING_CLEAR: assert property ((ovf && q.clr_armed && sc_wr) |=> q.overflow_flag && !q.clr_armed)
    else $error("overflow lost during clear");

  AST_WRITE_ONE_KEEPS: assert property ((sc_wr && q.overflow_flag && hwdata[7]) |=> q.overflow_flag)
    else $error("writing one changed the flag");

  // same cycle: a clearing write may drop the flag at the next edge
  AST_IRQ_FOLLOWS: assert property ((q.overflow_flag && q.overflow_irq_enable) |-> q.irq)
    else $error("overflow interrupt missing");

  AST_IRQ_DISABLED: assert property ((!q.overflow_irq_enable && !(|(q.evt_sts & q.evt_en))) |-> !q.irq)
    else $error("interrupt raised while disabled");

  AST_ARM_ON_READ: assert property ((acc && !hwrite && rd_addr == tcc_pkg::OFS_STATUS_CONTROL && q.overflow_flag
                                     && !ovf) |=> q.clr_armed)
    else $error("status read did not arm the clear");

  AST_ZERO_UNARMED_KEEPS: assert property ((sc_wr && !q.clr_armed && q.overflow_flag) |=> q.overflow_flag)
    else $error("flag cleared without prior read");

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");

  AST_UP_ONLY: assert property (!q.center_align_select |-> !q.down)
    else $error("down phase outside center mode");

  AST_CENTER_TOP: assert property ((cnt_en && q.center_align_select && !q.down && q.cnt >= top && !wr)
                                   |=> q.down)
    else $error("center mode did not turn at top");

  AST_CENTER_BOTTOM: assert property ((cnt_en && q.center_align_select && q.down && q.cnt == 16'h0000 && !wr)
                                      |=> !q.down && q.cnt == 16'h0001)
    else $error("center mode did not turn at bottom");

  AST_FIXED_AS_BUS: assert property ((q.clock_source_select == tcc_pkg::CLKSRC_FIXED && !fll_enabled)
                                     |-> src_tick)
    else $error("fixed source without fll not at bus rate");

  AST_FIXED_EDGE: assert property ((q.clock_source_select == tcc_pkg::CLKSRC_FIXED && fll_enabled && src_tick)
                                   |-> fixed_clk_sync && !$past(fixed_clk_sync))
    else $error("fixed tick without rising edge");

  AST_EXT_SYNC: assert property ((q.clock_source_select == tcc_pkg::CLKSRC_EXTERNAL && src_tick)
                                 |-> $past(ext_clk, 2) && !$past(ext_clk, 3))
    else $error("external tick not from synchronised edge");

  AST_PRE_IDLE: assert property ((!src_tick && !cnt_wr) |=> $stable(q.pre))
    else $error("prescaler moved without source tick");

  AST_PRE_STEP: assert property ((src_tick && !debug_halt_state && !cnt_wr)
                                 |=> q.pre == $past(q.pre) + 7'h01)
    else $error("prescaler did not step on tick");

  AST_HALT_PRE: assert property ((debug_halt_state && !cnt_wr) |=> $stable(q.pre))
    else $error("prescaler moved in halt");

  AST_HALT_REARM: assert property ((debug_halt_state && cnt_wr) |=> !q.held)
    else $error("counter write in halt did not rearm");

  AST_UP_STEP: assert property ((cnt_en && !q.center_align_select && q.cnt != top && !wr)
                                |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("counter did not step up");

  AST_DOWN_STEP: assert property ((cnt_en && q.center_align_select && q.down && q.cnt != 16'h0000 && !wr)
                                  |=> q.cnt == $past(q.cnt) - 16'h0001)
    else $error("counter did not step down");

  AST_NO_SOURCE_HOLDS: assert property ((q.clock_source_select == 2'h0 && !cnt_wr) |=> $stable(q.cnt))
    else $error("counter moved with no source");

  AST_HALT_FREEZE: assert property ((debug_halt_state && !wr) |=> $stable(q.cnt) && $stable(q.held))
    else $error("counter or latch moved in halt");

  AST_SC_WRITE_REARMS: assert property (sc_wr |=> !q.held)
    else $error("latch not rearmed by control write");

  AST_CNT_WRITE_ZERO: assert property (cnt_wr |=> q.cnt == 16'h0000 && !q.held)
    else $error("counter write did not zero counter");

  AST_BUS_DIV1: assert property ((q.clock_source_select == 2'h1 && q.prescale_select == 3'h0
                                  && !debug_halt_state && !wr && !q.center_align_select) |=> !$stable(q.cnt))
    else $error("divide-by-one did not step");

  AST_LATCH_HOLDS: assert property ((q.held && !wr && !acc) |=> $stable(q.latch) && q.held)
    else $error("latch changed without access");

  AST_WRAP_ZERO: assert property ((cnt_en && !q.center_align_select && q.cnt == top && !wr) |=> q.cnt == 16'h0000)
    else $error("counter did not wrap to zero");

endmodule : tcc_core

`default_nettype wire

// *** rtl/tcc_pkg.sv ***
package tcc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNTER_HIGH = 8'h04;
  localparam logic [7:0] OFS_COUNTER_LOW = 8'h08;
  localparam logic [7:0] OFS_MODULO = 8'h0C;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVENT_CLEAR = 8'h14;
  localparam logic [7:0] OFS_EVENT_ENABLE = 8'h18;

  // timer_status_control field positions
  localparam int unsigned POS_OVERFLOW_FLAG = 7;
  localparam int unsigned POS_OVERFLOW_IRQ_ENABLE = 6;
  localparam int unsigned POS_CENTER_ALIGN_SELECT = 5;
  localparam int unsigned POS_CLOCK_SOURCE_HI = 4;
  localparam int unsigned POS_CLOCK_SOURCE_LO = 3;
  localparam int unsigned POS_PRESCALE_HI = 2;
  localparam int unsigned POS_PRESCALE_LO = 0;

  // event status / clear / enable layout
  localparam int unsigned EVT_WIDTH = 2;
  localparam int unsigned POS_EVT_OVERFLOW = 0;
  localparam int unsigned POS_EVT_BOTTOM_TURN = 1;

  // clock source encodings
  localparam logic [1:0] CLKSRC_NONE = 2'h0;
  localparam logic [1:0] CLKSRC_BUS = 2'h1;
  localparam logic [1:0] CLKSRC_FIXED = 2'h2;
  localparam logic [1:0] CLKSRC_EXTERNAL = 2'h3;

  // reset values
  localparam logic [1:0] RST_CLOCK_SOURCE = 2'h0;
  localparam logic [2:0] RST_PRESCALE = 3'h0;
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [EVT_WIDTH-1:0] RST_EVENTS = 2'h0;

  // free-running top when modulo is zero
  localparam logic [15:0] CNT_FREE_TOP = 16'hFFFF;
  localparam logic [15:0] MODULO_DISABLED = 16'h0000;

endpackage : tcc_pkg

// *** tb/tcc_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tcc_core_tb;
  localparam logic [7:0] SC = tcc_pkg::OFS_STATUS_CONTROL;
  localparam logic [7:0] CH = tcc_pkg::OFS_COUNTER_HIGH;
  localparam logic [7:0] CL = tcc_pkg::OFS_COUNTER_LOW;
  localparam logic [1:0] BUS = tcc_pkg::CLKSRC_BUS;
  localparam logic [1:0] FIX = tcc_pkg::CLKSRC_FIXED;
  localparam logic [1:0] EXT = tcc_pkg::CLKSRC_EXTERNAL;
  localparam logic [1:0] NONE = tcc_pkg::CLKSRC_NONE;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, center_align_select, count_down;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] modulo_value, v1, v2;
  logic debug_halt_state, fll_enabled, fixed_clk_sync, ext_clk, tog_en;
  int fail_count, checks, cyc, seed, m;

  tcc_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .modulo_value(modulo_value), .debug_halt_state(debug_halt_state),
    .fll_enabled(fll_enabled), .fixed_clk_sync(fixed_clk_sync), .ext_clk(ext_clk), .irq(irq),
    .center_align_select(center_align_select), .count_down(count_down));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // timeout ceiling well above the longest prescale run
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      test_done();
    end
  end

  // fixed ticks every 4 cycles, external every 8, inside the quarter-rate limit
  always @(posedge hclk) begin
    if (tog_en) begin
      fixed_clk_sync <= cyc[1];
      ext_clk <= cyc[2];
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_val

  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi, input string msg);
    checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %0d", $time, msg, got);
    end
  endtask : chk_rng

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge hclk);
    chk_val({31'h0, irq}, {31'h0, exp}, "irq");
  endtask : irq_is

  task automatic rdcnt(output logic [15:0] v);
    logic [7:0] l;
    bus(1'b0, CL, 32'h0);
    l = rd[7:0];
    bus(1'b0, CH, 32'h0);
    v = {rd[7:0], l};
  endtask : rdcnt

  // zero, run n cycles from the chosen source, stop, read back
  task automatic run_cnt(input logic [1:0] s, input logic [2:0] p, input int n, output logic [15:0] v);
    bus(1'b1, CL, $random(seed));
    bus(1'b1, SC, {27'h0, s, p});
    repeat (n) @(posedge hclk);
    bus(1'b1, SC, 32'h0);
    rdcnt(v);
  endtask : run_cnt

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, debug_halt_state, fll_enabled, fixed_clk_sync, ext_clk, tog_en} = 8'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    modulo_value = 16'h0000;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    seed = 35065;
    m = 4 + ($unsigned($random(seed)) % 8);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, SC, 32'h0);
    chk_val(rd, 32'h0, "control reset");
    chk_val({30'h0, hresp, hreadyout}, 32'h1, "bus okay");
    rdcnt(v1);
    chk_val({16'h0, v1}, 32'h0, "counter reset");
    chk_val({31'h0, center_align_select}, 32'h0, "center reset");
    for (int p = 0; p < 8; p++) begin
      run_cnt(BUS, p[2:0], 64 << p, v1);
      chk_rng(v1, 62, 68, "prescale");
    end
    tog_en <= 1'b1;
    run_cnt(FIX, 3'h0, 64, v1);
    chk_rng(v1, 62, 68, "fixed without fll");
    @(posedge hclk) fll_enabled <= 1'b1;
    run_cnt(FIX, 3'h0, 64, v1);
    chk_rng(v1, 14, 18, "fixed with fll");
    run_cnt(EXT, 3'h0, 64, v1);
    chk_rng(v1, 6, 10, "external");
    run_cnt(EXT, 3'h1, 64, v1);
    chk_rng(v1, 3, 5, "external prescaled");
    run_cnt(NONE, 3'h0, 64, v1);
    chk_val({16'h0, v1}, 32'h0, "no source");
    // read latch: a reread of one byte keeps the capture
    bus(1'b1, CL, 32'h0);
    bus(1'b1, SC, 32'h08);
    bus(1'b0, CL, 32'h0);
    v1 = rd[15:0];
    repeat (5) @(posedge hclk);
    bus(1'b0, CL, 32'h0);
    chk_val(rd, {16'h0, v1}, "latch held");
    bus(1'b1, SC, 32'h08);
    bus(1'b0, CL, 32'h0);
    chk_rng(rd[15:0] - v1, 5, 40, "latch rearmed");
    bus(1'b0, CH, 32'h0);
    chk_val(rd, 32'h0, "high byte");
    @(posedge hclk) debug_halt_state <= 1'b1;
    rdcnt(v1);
    repeat (20) @(posedge hclk);
    rdcnt(v2);
    chk_val({16'h0, v2}, {16'h0, v1}, "halt freeze");
    bus(1'b1, CH, $random(seed));
    rdcnt(v1);
    chk_val({16'h0, v1}, 32'h0, "halt write");
    @(posedge hclk) debug_halt_state <= 1'b0;
    // overflow flag and its two-step clear
    modulo_value <= m[15:0];
    bus(1'b1, CL, 32'h0);
    bus(1'b1, SC, 32'h08);
    repeat (m + 4) @(posedge hclk);
    bus(1'b0, SC, 32'h0);
    chk_val(rd, 32'h88, "flag set");
    repeat (2 * m + 4) @(posedge hclk);
    bus(1'b1, SC, 32'h0);
    bus(1'b0, SC, 32'h0);
    chk_val(rd, 32'h80, "flag restart");
    irq_is(1'b0);
    bus(1'b1, SC, 32'hC0);
    irq_is(1'b1);
    bus(1'b1, SC, 32'h40);
    irq_is(1'b1);
    bus(1'b0, SC, 32'h0);
    chk_val(rd, 32'hC0, "flag kept");
    bus(1'b1, SC, 32'h40);
    irq_is(1'b0);
    bus(1'b0, tcc_pkg::OFS_EVENT_STATUS, 32'h0);
    chk_val(rd, 32'h1, "event status");
    bus(1'b1, tcc_pkg::OFS_EVENT_ENABLE, 32'h1);
    irq_is(1'b1);
    bus(1'b1, tcc_pkg::OFS_EVENT_CLEAR, 32'h1);
    irq_is(1'b0);
    bus(1'b0, tcc_pkg::OFS_EVENT_STATUS, 32'h0);
    chk_val(rd, 32'h0, "event cleared");
    // center mode turns at the top and again at the bottom
    bus(1'b1, CL, 32'h0);
    bus(1'b1, SC, 32'h28);
    @(posedge hclk);
    chk_val({31'h0, center_align_select}, 32'h1, "center out");
    for (int i = 0; i < 2 * m + 8 && count_down !== 1'b1; i++) @(posedge hclk);
    chk_val({31'h0, count_down}, 32'h1, "down phase");
    repeat (3 * m + 8) @(posedge hclk);
    bus(1'b0, tcc_pkg::OFS_EVENT_STATUS, 32'h0);
    chk_val(rd, 32'h3, "center turns");
    bus(1'b1, SC, 32'h0);
    bus(1'b0, 8'h1C, 32'h0);
    chk_val(rd, 32'h0, "unmapped");
    test_done();
  end
endmodule : tcc_core_tb

`default_nettype wire
